// ===== logic/ext_bus_pkg.sv
// Purpose: Shared constants for the external memory and I/O bus interface.
// Assumes: 16-bit address and data, one core clock domain.
// Notes: Output clock runs at half the core clock rate.
package ext_bus_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int WS_W = 3;
    // Wait-state control register, in I/O space
    localparam logic [15:0] WS_CTRL_ADDR = 16'hFFFF;
    localparam logic [15:0] WS_CTRL_RESET = 16'h01FF;
    localparam int WS_PROG_LSB = 0;
    localparam int WS_DATA_LSB = 3;
    localparam int WS_IO_LSB = 6;
    localparam logic [15:0] WS_CTRL_MASK = 16'h01FF;
    // Global map register, in data space
    localparam logic [15:0] GMAP_ADDR = 16'h0005;
    localparam logic [7:0] GMAP_RESET = 8'h00;
    // Memory map
    localparam logic [15:0] DATA_EXT_BASE = 16'h8000;
    localparam logic [15:0] PROG_INT_TOP = 16'h1FFF;
    localparam logic [15:0] ILLEGAL_LO = 16'h0800;
    localparam logic [15:0] ILLEGAL_HI = 16'h6FFF;
    localparam logic [WS_W-1:0] WS_ZERO = 3'h0;
    typedef enum logic [1:0] {SP_PROG, SP_DATA, SP_IO} space_t;
    typedef enum logic [1:0] {OP_FETCH, OP_READ, OP_WRITE} op_t;
    typedef enum {S_IDLE, S_BUS} state_t;
endpackage : ext_bus_pkg

// ===== logic/ext_bus_iface.sv
// Purpose: External bus sequencer: fetch, data read and data write onto one bus.
// Assumes: Core holds each request until its done pulse, drops it next cycle.
// Notes: On-chip memory itself lives elsewhere; internal hits get a done, plus register access or NMI where mapped.
`timescale 1ns/1ps
// Functional notes
// - Drive 16-bit address and data buses with three space selects.
// - Same-cycle requests go out as write, then data read, then fetch.
// - Upper data half maps global by register; global access drives request low.
// - Read/write output shows direction of current external cycle.
// - Strobe marks timing of every external cycle.
// - Separate read and write enables, each only in its own cycle.
// - Reads may take zero waits; writes take at least two cycles.
// - Each wait state adds one output-clock cycle, aligned to boundaries.
// - Ready low means wait one output cycle and sample again.
// - Ready ignored for internal accesses.
// - Generator inserts zero to seven waits per space, regardless of ready.
// - Wait counts live in a register at the top I/O address.
// - External data space is limited to the upper 32K words.
// - I/O uses the same buses and sequencing, only its select differs.
// - Access to an illegal address raises the non-maskable interrupt.
module ext_bus_iface
    import ext_bus_pkg::*;
(
    input wire logic core_clk, // 200 MHz core clock
    input wire logic rst_b, // synchronous reset, active low
    input wire logic fetch_req, // program fetch request
    input wire logic [ADDR_W-1:0] fetch_addr, // fetch address
    output logic fetch_done, // fetch complete pulse
    output logic [DATA_W-1:0] fetch_data, // fetched word
    input wire logic dread_req, // data read request
    input wire logic dread_io, // read targets I/O space
    input wire logic [ADDR_W-1:0] dread_addr, // read address
    output logic dread_done, // read complete pulse
    output logic [DATA_W-1:0] dread_data, // read word
    input wire logic dwrite_req, // data write request
    input wire logic dwrite_io, // write targets I/O space
    input wire logic [ADDR_W-1:0] dwrite_addr, // write address
    input wire logic [DATA_W-1:0] dwrite_data, // write word
    output logic dwrite_done, // write complete pulse
    output logic [ADDR_W-1:0] ext_addr, // external address bus
    input wire logic [DATA_W-1:0] ext_data_in, // external data bus in
    output logic [DATA_W-1:0] ext_data_out, // external data bus out
    output logic ext_data_oe, // data bus drive enable
    output logic read_not_write, // high on read cycles
    output logic cycle_strobe_n, // external cycle strobe
    output logic rd_n, // read enable
    output logic we_n, // write enable
    output logic program_space_sel_n, // program space select
    output logic data_space_sel_n, // data space select
    output logic io_space_sel_n, // I/O space select
    output logic global_bus_request_n, // global memory bus request
    input wire logic ready, // external ready
    output logic output_clock, // bus timing clock, half core rate
    output logic nmi_req, // illegal access pulse
    output logic [DATA_W-1:0] wait_state_control, // wait-state register value
    output logic [7:0] global_map_register // global map register value
);
    state_t state_r, state_nxt;
    op_t op_r, op_nxt;
    space_t space_r, space_nxt;
    logic phase_r, phase_nxt;
    logic first_r, first_nxt;
    logic glob_r, glob_nxt;
    logic [WS_W:0] cnt_r, cnt_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic [DATA_W-1:0] wdata_r, wdata_nxt;
    logic [DATA_W-1:0] rdata_r, rdata_nxt;
    logic [DATA_W-1:0] ws_r, ws_nxt;
    logic [7:0] gmap_r, gmap_nxt;
    logic fd_r, fd_nxt, rd_r, rd_nxt, wd_r, wd_nxt, nmi_r, nmi_nxt;
    // Selected pending request
    logic any_req;
    op_t sel_op;
    space_t sel_space;
    logic [ADDR_W-1:0] sel_addr;
    logic sel_internal, sel_illegal;
    logic [WS_W-1:0] sel_ws;

    always_comb begin
        any_req = 1'b1;
        sel_op = OP_FETCH;
        sel_space = SP_PROG;
        sel_addr = fetch_addr;
        if (dwrite_req && !wd_r) begin
            sel_op = OP_WRITE;
            sel_space = dwrite_io ? SP_IO : SP_DATA;
            sel_addr = dwrite_addr;
        end else if (dread_req && !rd_r) begin
            sel_op = OP_READ;
            sel_space = dread_io ? SP_IO : SP_DATA;
            sel_addr = dread_addr;
        end else if (!(fetch_req && !fd_r)) begin
            any_req = 1'b0;
        end
        sel_illegal = 1'b0;
        sel_internal = 1'b0;
        sel_ws = ws_r[WS_PROG_LSB +: WS_W];
        case (sel_space)
            SP_PROG: begin
                sel_internal = (sel_addr <= PROG_INT_TOP);
            end
            SP_DATA: begin
                // illegal hole in the data map
                sel_illegal = (sel_addr >= ILLEGAL_LO) && (sel_addr <= ILLEGAL_HI);
                // only the upper half of data space is external
                sel_internal = (sel_addr < DATA_EXT_BASE);
                sel_ws = ws_r[WS_DATA_LSB +: WS_W];
            end
            SP_IO: begin
                sel_internal = (sel_addr == WS_CTRL_ADDR);
                sel_ws = ws_r[WS_IO_LSB +: WS_W];
            end
            default: begin
                sel_internal = 1'b1;
            end
        endcase
    end

    always_comb begin
        state_nxt = state_r;
        op_nxt = op_r;
        space_nxt = space_r;
        phase_nxt = ~phase_r;
        first_nxt = first_r;
        glob_nxt = glob_r;
        cnt_nxt = cnt_r;
        addr_nxt = addr_r;
        wdata_nxt = wdata_r;
        rdata_nxt = rdata_r;
        ws_nxt = ws_r;
        gmap_nxt = gmap_r;
        fd_nxt = 1'b0;
        rd_nxt = 1'b0;
        wd_nxt = 1'b0;
        nmi_nxt = 1'b0;
        case (state_r)
            S_IDLE: begin
                if (any_req && (sel_internal || sel_illegal)) begin
                    // internal hits finish at once, ready unused
                    nmi_nxt = sel_illegal;
                    rdata_nxt = '0;
                    if (sel_op == OP_WRITE) begin
                        if (sel_space == SP_IO && sel_addr == WS_CTRL_ADDR) begin
                            // wait counts written at top I/O address
                            ws_nxt = dwrite_data & WS_CTRL_MASK;
                        end
                        if (sel_space == SP_DATA && sel_addr == GMAP_ADDR) begin
                            gmap_nxt = dwrite_data[7:0];
                        end
                        wd_nxt = 1'b1;
                    end else if (sel_op == OP_READ) begin
                        if (sel_space == SP_IO && sel_addr == WS_CTRL_ADDR) begin
                            rdata_nxt = ws_r;
                        end
                        if (sel_space == SP_DATA && sel_addr == GMAP_ADDR) begin
                            rdata_nxt = {8'h00, gmap_r};
                        end
                        rd_nxt = 1'b1;
                    end else begin
                        fd_nxt = 1'b1;
                    end
                end else if (any_req && phase_r) begin
                    // external cycles start on an output-clock boundary
                    state_nxt = S_BUS;
                    op_nxt = sel_op;
                    space_nxt = sel_space;
                    addr_nxt = sel_addr;
                    wdata_nxt = dwrite_data;
                    first_nxt = 1'b1;
                    // global when at or above the mapped base in upper half
                    glob_nxt = (sel_space == SP_DATA) && (gmap_r != 8'h00)
                        && (sel_addr[15:8] >= gmap_r);
                    // generated waits, plus one cycle for writes
                    cnt_nxt = {1'b0, sel_ws} + ((sel_op == OP_WRITE) ? 4'h1 : 4'h0);
                end
            end
            S_BUS: begin
                if (phase_r) begin
                    first_nxt = 1'b0;
                    if (cnt_r != 4'h0) begin
                        // one output cycle per wait state
                        cnt_nxt = cnt_r - 4'h1;
                    end else if (ready) begin
                        // finish only when ready is sampled high
                        state_nxt = S_IDLE;
                        glob_nxt = 1'b0;
                        rdata_nxt = ext_data_in;
                        fd_nxt = (op_r == OP_FETCH);
                        rd_nxt = (op_r == OP_READ);
                        wd_nxt = (op_r == OP_WRITE);
                    end
                end
            end
            default: begin
                state_nxt = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state_r <= S_IDLE;
            op_r <= OP_FETCH;
            space_r <= SP_PROG;
            phase_r <= 1'b0;
            first_r <= 1'b0;
            glob_r <= 1'b0;
            cnt_r <= 4'h0;
            addr_r <= 16'h0000;
            wdata_r <= 16'h0000;
            rdata_r <= 16'h0000;
            ws_r <= WS_CTRL_RESET;
            gmap_r <= GMAP_RESET;
            fd_r <= 1'b0;
            rd_r <= 1'b0;
            wd_r <= 1'b0;
            nmi_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            op_r <= op_nxt;
            space_r <= space_nxt;
            phase_r <= phase_nxt;
            first_r <= first_nxt;
            glob_r <= glob_nxt;
            cnt_r <= cnt_nxt;
            addr_r <= addr_nxt;
            wdata_r <= wdata_nxt;
            rdata_r <= rdata_nxt;
            ws_r <= ws_nxt;
            gmap_r <= gmap_nxt;
            fd_r <= fd_nxt;
            rd_r <= rd_nxt;
            wd_r <= wd_nxt;
            nmi_r <= nmi_nxt;
        end
    end

    logic bus_on, wr_on, half_in;
    assign bus_on = (state_r == S_BUS);
    assign wr_on = bus_on && (op_r == OP_WRITE);
    // Half a cycle of turnaround before the data bus is driven
    assign half_in = first_r && !phase_r;
    // one address and data bus for all spaces
    assign ext_addr = addr_r;
    assign ext_data_out = wdata_r;
    // data drive held off for the first half output cycle
    assign ext_data_oe = wr_on && !half_in;
    assign read_not_write = !wr_on;
    // strobe low for the whole external cycle
    assign cycle_strobe_n = !bus_on;
    // enables only in their own cycle type
    assign rd_n = !(bus_on && op_r != OP_WRITE);
    assign we_n = !(wr_on && !half_in);
    // one space select during a cycle, none otherwise
    assign program_space_sel_n = !(bus_on && space_r == SP_PROG);
    assign data_space_sel_n = !(bus_on && space_r == SP_DATA);
    assign io_space_sel_n = !(bus_on && space_r == SP_IO);
    // bus request held through the global access
    assign global_bus_request_n = !(bus_on && glob_r);
    assign output_clock = !phase_r;
    assign fetch_done = fd_r;
    assign dread_done = rd_r;
    assign dwrite_done = wd_r;
    assign fetch_data = rdata_r;
    assign dread_data = rdata_r;
    assign nmi_req = nmi_r;
    assign wait_state_control = ws_r;
    assign global_map_register = gmap_r;
endmodule : ext_bus_iface

// ===== test/ext_mem_model.sv
// Purpose: External memory partner that can stretch cycles with ready.
// Assumes: 16-word array indexed by the low address bits.
// Notes: A released bus shows the inverted last word, never a stale copy.
`timescale 1ns/1ps
module ext_mem_model (
    input wire logic core_clk, // core clock
    input wire logic [15:0] ext_addr, // address bus
    input wire logic [15:0] ext_data_out, // write data
    input wire logic cycle_strobe_n, // cycle strobe
    input wire logic rd_n, // read enable
    input wire logic we_n, // write enable
    input wire logic rdy_en, // ready gate from bench
    input wire logic [31:0] stall, // core cycles of ready low
    output logic [15:0] ext_data_in, // read data
    output logic ready // ready to device
);
    logic [15:0] mem [16];
    logic [15:0] last = 16'h0000;
    int cnt = 0;
    assign ready = rdy_en && (cycle_strobe_n || cnt >= stall);
    assign ext_data_in = !rd_n ? mem[ext_addr[3:0]] : ~last;
    always @(posedge core_clk) begin
        cnt <= cycle_strobe_n ? 0 : cnt + 1;
        if (!rd_n) last <= mem[ext_addr[3:0]];
        if (!we_n) mem[ext_addr[3:0]] <= ext_data_out;
    end
endmodule : ext_mem_model

// ===== test/ext_bus_iface_checker.sv
// Purpose: Bus protocol assertions at the sequencer ports.
// Assumes: Single core clock domain.
// Notes: Attached by bind at the foot.
`timescale 1ns/1ps
module ext_bus_iface_checker (
    input wire logic core_clk, // clock
    input wire logic rst_b, // reset
    input wire logic ready, // ready
    input wire logic cycle_strobe_n, // strobe
    input wire logic rd_n, // read enable
    input wire logic we_n, // write enable
    input wire logic read_not_write, // direction
    input wire logic ext_data_oe, // data bus drive enable
    input wire logic program_space_sel_n, // select
    input wire logic data_space_sel_n, // select
    input wire logic io_space_sel_n, // select
    input wire logic global_bus_request_n, // request
    input wire logic output_clock, // bus clock
    input wire logic fetch_done, // done
    input wire logic dread_done, // done
    input wire logic dwrite_done // done
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    a_one_select: assert property (
        !cycle_strobe_n |-> $onehot(~{program_space_sel_n, data_space_sel_n, io_space_sel_n}))
        else $error("space select not one-hot");
    a_idle_deselect: assert property (
        cycle_strobe_n |-> &{program_space_sel_n, data_space_sel_n, io_space_sel_n})
        else $error("select outside cycle");
    a_read_enable: assert property (
        !rd_n |-> read_not_write && !cycle_strobe_n && we_n) else $error("bad read enable");
    a_write_enable: assert property (
        !we_n |-> !read_not_write && !cycle_strobe_n && rd_n) else $error("bad write enable");
    a_drive_turn: assert property (
        ext_data_oe |-> !we_n && !read_not_write && !$past(read_not_write))
        else $error("data driven without turnaround");
    a_write_min: assert property (
        $fell(we_n) |-> !$past(cycle_strobe_n) ##0 !cycle_strobe_n[*3])
        else $error("write too short");
    a_strobe_align: assert property (
        $changed(cycle_strobe_n) |-> output_clock) else $error("strobe off boundary");
    a_ready_stall: assert property (
        !cycle_strobe_n && !ready |=> !cycle_strobe_n) else $error("ready low ignored");
    a_global_data: assert property (
        !global_bus_request_n |-> !data_space_sel_n && !cycle_strobe_n)
        else $error("request outside data cycle");
    a_done_end: assert property (
        $rose(cycle_strobe_n) |-> fetch_done || dread_done || dwrite_done)
        else $error("cycle end without done");
endmodule : ext_bus_iface_checker
bind ext_bus_iface ext_bus_iface_checker chk_i (.core_clk, .rst_b, .ready, .cycle_strobe_n,
    .rd_n, .we_n, .read_not_write, .ext_data_oe, .program_space_sel_n, .data_space_sel_n,
    .io_space_sel_n,
    .global_bus_request_n, .output_clock, .fetch_done, .dread_done, .dwrite_done);

// ===== test/ext_bus_iface_tb.sv
// Purpose: Self-checking bench for the external bus sequencer.
// Assumes: Partner memory answers every space alike.
// Notes: Lengths are counted as core cycles with strobe low.
`timescale 1ns/1ps
module ext_bus_iface_tb;
    import ext_bus_pkg::*;
    logic core_clk = 0, rst_b = 0, rdy_en = 1;
    logic fetch_req = 0, dread_req = 0, dread_io = 0, dwrite_req = 0, dwrite_io = 0;
    logic [15:0] fetch_addr = '0, dread_addr = '0, dwrite_addr = '0, dwrite_data = '0;
    logic fetch_done, dread_done, dwrite_done, ext_data_oe, read_not_write, cycle_strobe_n;
    logic rd_n, we_n, program_space_sel_n, data_space_sel_n, io_space_sel_n;
    logic global_bus_request_n, ready, output_clock, nmi_req, prev_s = 1;
    logic [15:0] fetch_data, dread_data, ext_addr, ext_data_in, ext_data_out;
    logic [15:0] wait_state_control;
    logic [7:0] global_map_register;
    logic [5:0] seq = '0;
    int errors = 0, checks_done = 0, stall = 0, sl = 0, gl = 0, nm = 0;
    ext_bus_iface dut (.*);
    ext_mem_model mem_i (.*);
    always #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        prev_s <= cycle_strobe_n;
        if (!cycle_strobe_n) sl <= sl + 1;
        if (!global_bus_request_n) gl <= gl + 1;
        if (nmi_req === 1'b1) nm <= nm + 1;
        if (prev_s && !cycle_strobe_n) seq <= {seq[3:0], ~program_space_sel_n, read_not_write};
    end
    function automatic int blen(int w, int n);
        return (1 + n + w) * 2;
    endfunction : blen
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            errors++;
            $display("FAIL %s expected %0h seen %0h", n, e, s);
        end
    endtask : chk
    task end_of_test;
        if (errors == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_of_test
    task automatic acc(input int op, input logic io, input logic [15:0] a, d,
            output logic [15:0] q);
        logic got;
        got = 0;
        @(negedge core_clk);
        if (op == 0) begin fetch_req = 1; fetch_addr = a; end
        else if (op == 1) begin dread_req = 1; dread_io = io; dread_addr = a; end
        else begin dwrite_req = 1; dwrite_io = io; dwrite_addr = a; dwrite_data = d; end
        for (int i = 0; i < 300 && !got; i++) begin
            @(posedge core_clk);
            #1;
            got = op == 0 ? fetch_done : op == 1 ? dread_done : dwrite_done;
        end
        q = op == 0 ? fetch_data : dread_data;
        chk("done", got, 1);
        @(negedge core_clk);
        if (op == 0) fetch_req = 0;
        else if (op == 1) dread_req = 0;
        else dwrite_req = 0;
    endtask : acc
    initial begin
        #100000;
        errors++;
        end_of_test;
    end
    initial begin
        logic [15:0] q, q1, q2, q3, a, d;
        logic [8:0] ws;
        logic io;
        int n, s0;
        void'($urandom(75));
        repeat (8) @(negedge core_clk);
        rst_b = 1;
        chk("wsc_rst", wait_state_control, 16'h01FF);
        chk("gmap_rst", global_map_register, 8'h00);
        repeat (12) begin
            ws = 9'($urandom);
            io = 1'($urandom);
            acc(2, 1, WS_CTRL_ADDR, {7'h00, ws}, q);
            acc(1, 1, WS_CTRL_ADDR, '0, q);
            chk("wsc", q, {7'h00, ws});
            n = io ? ws[8:6] : ws[5:3];
            a = {io ? 12'h001 : 12'h800, 4'($urandom)};
            d = 16'($urandom);
            s0 = sl;
            acc(2, io, a, d, q);
            chk("wlen", sl - s0, blen(1, n));
            s0 = sl;
            acc(1, io, a, '0, q);
            chk("rlen", sl - s0, blen(0, n));
            chk("rdat", q, d);
            s0 = sl;
            acc(0, 0, {12'h200, a[3:0]}, '0, q);
            chk("flen", sl - s0, blen(0, ws[2:0]));
            chk("fdat", q, d);
        end
        acc(2, 1, WS_CTRL_ADDR, '0, q);
        fork
            acc(0, 0, 16'h2005, '0, q1);
            acc(1, 0, 16'h8006, '0, q2);
            acc(2, 0, 16'h8007, 16'hA5A5, q3);
        join
        chk("order", seq, 6'h07);
        acc(2, 0, GMAP_ADDR, 16'h0090, q);
        chk("gmap", global_map_register, 8'h90);
        acc(1, 0, GMAP_ADDR, '0, q);
        chk("gmap_rd", q, 16'h0090);
        // one data wait while ready stretches
        acc(2, 1, WS_CTRL_ADDR, 16'h0008, q);
        s0 = gl;
        acc(1, 0, 16'h8F00, '0, q);
        chk("local", gl - s0, 0);
        stall = 5;
        s0 = gl;
        acc(1, 0, 16'h9000, '0, q);
        chk("global", gl > s0, 1);
        acc(2, 0, GMAP_ADDR, 16'h0000, q);
        stall = 7;
        s0 = sl;
        acc(1, 0, 16'h8001, '0, q);
        n = sl - s0;
        chk("stall", n % 2 == 0 && n > stall && n <= stall + 4, 1);
        stall = 0;
        rdy_en = 0;
        s0 = sl;
        acc(1, 0, 16'h0100, '0, q);
        chk("internal", sl - s0, 0);
        chk("int_dat", q, 16'h0000);
        rdy_en = 1;
        n = nm;
        acc(1, 0, 16'h07FF, '0, q);
        acc(1, 0, ILLEGAL_LO, '0, q);
        acc(2, 0, ILLEGAL_HI, 16'h1111, q);
        acc(1, 0, 16'h7000, '0, q);
        chk("nmi", nm - n, 2);
        chk("nmi_bus", sl - s0, 0);
        end_of_test;
    end
endmodule : ext_bus_iface_tb
